/* ackctl_pkg.sv */
// Constants and carrier types for the acknowledge-bit control block
package ackctl_pkg;

	// ==================================================
	// Reset values
	localparam logic ACK_VALUE_RST = 1'h0;
	localparam logic ACK_FLAG_RST = 1'h0;
	localparam logic CHECK_EN_RST = 1'h0;

	// ==================================================
	// Bit position of the acknowledge bit in the bus status register
	localparam int ACK_VALUE_BIT_POS = 0;

	// ==================================================
	// Byte framing counts, counted in SCL falling edges
	localparam int BIT_CNT_W = 4;
	localparam logic [BIT_CNT_W-1:0] BIT_CNT_RST = 4'h0;
	localparam logic [BIT_CNT_W-1:0] ACK_SLOT_CNT = 4'h8;

	// ==================================================
	// Synchroniser depth for pin inputs
	localparam int SYNC_STAGES = 2;

	// ==================================================
	// Software write strobes with their data, all on CORE_CLK
	typedef struct packed {
		logic ack_wr;
		logic ack_wdata;
		logic check_wr;
		logic check_wdata;
	} ackctl_sw_s;

	// Synchronised pin levels
	typedef struct packed {
		logic scl;
		logic sda;
	} ackctl_pins_s;

endpackage

/* ackctl_sync.sv */
// Two-flop synchroniser for the bus pin inputs
`timescale 1ns/1ps
module ackctl_sync
#(
	parameter int WIDTH = 2
)
(
	input wire logic CORE_CLK,
	input wire logic SYS_RST,
	input wire logic [WIDTH-1:0] ASYNC_IN,
	output logic [WIDTH-1:0] SYNC_OUT
);

	// ==================================================
	// Stage registers
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;
	logic [WIDTH-1:0] nxt_meta;
	logic [WIDTH-1:0] nxt_sync;

	// First stage feeds only the second stage; idle bus level is high
	always_comb
	begin
		nxt_meta = ASYNC_IN;
		nxt_sync = meta_ff;
	end

	// Register both stages
	always_ff @(posedge CORE_CLK)
	begin
		if (SYS_RST)
		begin
			meta_ff <= '1;
			sync_ff <= '1;
		end
		else
		begin
			meta_ff <= nxt_meta;
			sync_ff <= nxt_sync;
		end
	end

	assign SYNC_OUT = sync_ff;

endmodule

/* ackctl_top.sv */
// Acknowledge-bit control: capture in transmit mode, return in receive mode
`timescale 1ns/1ps
module ackctl_top
(
	input wire logic CORE_CLK,
	input wire logic SYS_RST,
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE_N,
	input wire logic TRANSMIT_SELECT,
	input wire logic BYTE_START,
	input wire ackctl_pkg::ackctl_sw_s SW_CTRL,
	output logic [7:0] BUS_STATUS_REGISTER,
	output logic ACK_VALUE_BIT,
	output logic ACK_CHECK_ENABLE,
	output logic ACK_FLAG,
	output logic ACK_SLOT
);

	// ==================================================
	// Pin synchronisation
	logic [1:0] pins_raw;
	logic [1:0] pins_sync;
	ackctl_pkg::ackctl_pins_s pins;

	assign pins_raw = {SCL_IN, SDA_IN};

	ackctl_sync
	#(
		.WIDTH(2)
	)
	u_sync
	(
		.CORE_CLK(CORE_CLK),
		.SYS_RST(SYS_RST),
		.ASYNC_IN(pins_raw),
		.SYNC_OUT(pins_sync)
	);

	assign pins = ackctl_pkg::ackctl_pins_s'(pins_sync);

	// ==================================================
	// SCL edge detection on the synchronised level
	logic scl_prev_ff;
	logic nxt_scl_prev;
	logic scl_rise;
	logic scl_fall;

	// Previous SCL level for edge detection
	always_comb
	begin
		nxt_scl_prev = pins.scl;
	end

	// Register the previous SCL level; idle-high reset avoids a false edge
	always_ff @(posedge CORE_CLK)
	begin
		if (SYS_RST)
			scl_prev_ff <= 1'h1;
		else
			scl_prev_ff <= nxt_scl_prev;
	end

	assign scl_rise = pins.scl & ~scl_prev_ff;
	assign scl_fall = ~pins.scl & scl_prev_ff;

	// ==================================================
	// Bit counter: counts SCL falls within a byte, slot is the ninth clock
	logic [ackctl_pkg::BIT_CNT_W-1:0] bit_cnt_ff;
	logic [ackctl_pkg::BIT_CNT_W-1:0] nxt_bit_cnt;
	logic in_slot;

	assign in_slot = (bit_cnt_ff == ackctl_pkg::ACK_SLOT_CNT);

	// Eight falls open the slot, the ninth fall closes it and starts the next byte
	// BYTE_START must follow the start condition's SCL fall, or that fall counts as a data clock
	always_comb
	begin
		nxt_bit_cnt = bit_cnt_ff;
		if (BYTE_START)
			nxt_bit_cnt = ackctl_pkg::BIT_CNT_RST;
		else if (scl_fall)
		begin
			if (in_slot)
				nxt_bit_cnt = ackctl_pkg::BIT_CNT_RST;
			else
				nxt_bit_cnt = bit_cnt_ff + 4'h1;
		end
	end

	// Register the bit count
	always_ff @(posedge CORE_CLK)
	begin
		if (SYS_RST)
			bit_cnt_ff <= ackctl_pkg::BIT_CNT_RST;
		else
			bit_cnt_ff <= nxt_bit_cnt;
	end

	// ==================================================
	// Acknowledge state: return setting, captured flag, check enable
	logic ack_value_ff;
	logic ack_flag_ff;
	logic check_en_ff;
	logic nxt_ack_value;
	logic nxt_ack_flag;
	logic nxt_check_en;
	logic capture;

	// Remote acknowledge is taken at the ninth SCL rise while transmitting with the check enabled
	assign capture = scl_rise & in_slot & TRANSMIT_SELECT & check_en_ff;

	// Next return setting, flag and enable; an ack write never moves the flag
	always_comb
	begin
		nxt_ack_value = ack_value_ff;
		nxt_ack_flag = ack_flag_ff;
		nxt_check_en = check_en_ff;
		// Any ack write sets the return value, also a write-back in transmit mode
		if (SW_CTRL.ack_wr)
			nxt_ack_value = SW_CTRL.ack_wdata;
		if (SW_CTRL.check_wr)
			nxt_check_en = SW_CTRL.check_wdata;
		// Clear by enable write first, so a capture in the same cycle wins
		if (SW_CTRL.check_wr && !SW_CTRL.check_wdata)
			nxt_ack_flag = 1'h0;
		if (capture)
			nxt_ack_flag = pins.sda;
	end

	// Register the acknowledge state
	always_ff @(posedge CORE_CLK)
	begin
		if (SYS_RST)
		begin
			ack_value_ff <= ackctl_pkg::ACK_VALUE_RST;
			ack_flag_ff <= ackctl_pkg::ACK_FLAG_RST;
			check_en_ff <= ackctl_pkg::CHECK_EN_RST;
		end
		else
		begin
			ack_value_ff <= nxt_ack_value;
			ack_flag_ff <= nxt_ack_flag;
			check_en_ff <= nxt_check_en;
		end
	end

	// ==================================================
	// SDA drive: pull low in the receive slot when returning 0, else release
	logic sda_oe_n_ff;
	logic nxt_sda_oe_n;

	// Next drive state; the next setting lets a write during the slot reach the line
	always_comb
	begin
		nxt_sda_oe_n = 1'h1;
		if (in_slot && !TRANSMIT_SELECT && !nxt_ack_value)
			nxt_sda_oe_n = 1'h0;
	end

	// Register the drive enable so SDA_OE_N is glitch free
	always_ff @(posedge CORE_CLK)
	begin
		if (SYS_RST)
			sda_oe_n_ff <= 1'h1;
		else
			sda_oe_n_ff <= nxt_sda_oe_n;
	end

	// ==================================================
	// Read view of the acknowledge bit
	logic read_ff;
	logic nxt_read;

	// Transmit shows the captured flag, receive shows the stored setting
	always_comb
	begin
		if (TRANSMIT_SELECT)
			nxt_read = nxt_ack_flag;
		else
			nxt_read = nxt_ack_value;
	end

	// Register the view; it lags TRANSMIT_SELECT by one cycle
	always_ff @(posedge CORE_CLK)
	begin
		if (SYS_RST)
			read_ff <= ackctl_pkg::ACK_VALUE_RST;
		else
			read_ff <= nxt_read;
	end

	// ==================================================
	// Outputs
	assign SDA_OUT = 1'h0; // Open drain: only ever drives low
	assign SDA_OE_N = sda_oe_n_ff;
	assign ACK_VALUE_BIT = read_ff;

	// Status view: only the acknowledge bit is carried, all other bits read 0
	always_comb
	begin
		BUS_STATUS_REGISTER = 8'h00;
		BUS_STATUS_REGISTER[ackctl_pkg::ACK_VALUE_BIT_POS] = read_ff;
	end

	assign ACK_CHECK_ENABLE = check_en_ff;
	assign ACK_FLAG = ack_flag_ff;
	assign ACK_SLOT = in_slot;

endmodule

/* ackctl_peer.sv */
// Remote bus master model driving SCL and SDA on a pulled-up bus
`timescale 1ns/1ps
module ackctl_peer
(
	input wire logic clk,
	input wire logic bus_sda,
	output logic scl,
	output logic sda,
	output logic bstart
);
	// ========
	// Idle bus: both lines released, clock stands still
	initial
	begin
		scl = 1'b1;
		sda = 1'b1;
		bstart = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Start, eight data clocks, ack clock, stop; got is the ack slot level
	task automatic xfer(input logic [7:0] d, input logic a, output logic got);
		sda <= 1'b0;
		tick(8);
		scl <= 1'b0;
		tick(4); // Let the start fall pass the synchroniser before realigning
		bstart <= 1'b1;
		tick(1);
		bstart <= 1'b0;
		for (int i = 0; i < 9; i++)
		begin
			tick(4);
			sda <= (i < 8) ? d[7-i] : a; // A 1 in the slot releases the line
			tick(4);
			scl <= 1'b1;
			tick(8);
			got = bus_sda;
			scl <= 1'b0;
		end
		tick(4);
		sda <= 1'b0;
		tick(4);
		scl <= 1'b1;
		tick(4);
		sda <= 1'b1;
	endtask
endmodule

/* ackctl_monitor.sv */
// Port checker for the acknowledge-bit control block
`timescale 1ns/1ps
module ackctl_monitor
(
	input wire logic CORE_CLK,
	input wire logic SYS_RST,
	input wire logic SDA_OE_N,
	input wire logic TRANSMIT_SELECT,
	input wire ackctl_pkg::ackctl_sw_s SW_CTRL,
	input wire logic [7:0] BUS_STATUS_REGISTER,
	input wire logic ACK_VALUE_BIT,
	input wire logic ACK_FLAG,
	input wire logic ACK_SLOT
);
	// ========
	// Assertions
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (SYS_RST);
	sequence s_rx_slot;
		$rose(ACK_SLOT) && !TRANSMIT_SELECT;
	endsequence
	a_reset_idle: assert property ($fell(SYS_RST) |-> SDA_OE_N && !ACK_FLAG && !ACK_VALUE_BIT)
		else $error("bad reset");
	a_status_map: assert property (BUS_STATUS_REGISTER == {7'h00, ACK_VALUE_BIT})
		else $error("bad status");
	a_check_clear: assert property (SW_CTRL.check_wr && !SW_CTRL.check_wdata && !ACK_SLOT |=> !ACK_FLAG)
		else $error("flag kept");
	a_rx_view: assert property (SW_CTRL.ack_wr && !TRANSMIT_SELECT |=> ACK_VALUE_BIT == $past(SW_CTRL.ack_wdata))
		else $error("bad rx view");
	a_tx_view: assert property ($past(TRANSMIT_SELECT) |-> ACK_VALUE_BIT == ACK_FLAG)
		else $error("bad tx view");
	a_drive_slot: assert property (!SDA_OE_N |-> $past(ACK_SLOT))
		else $error("drive off slot");
	a_tx_quiet: assert property ($past(TRANSMIT_SELECT) |-> SDA_OE_N)
		else $error("drive in tx");
	a_rx_return: assert property (s_rx_slot |=> SDA_OE_N == ACK_VALUE_BIT)
		else $error("bad ack out");
endmodule
bind ackctl_top ackctl_monitor mon (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .SDA_OE_N(SDA_OE_N),
	.TRANSMIT_SELECT(TRANSMIT_SELECT), .SW_CTRL(SW_CTRL), .BUS_STATUS_REGISTER(BUS_STATUS_REGISTER),
	.ACK_VALUE_BIT(ACK_VALUE_BIT), .ACK_FLAG(ACK_FLAG), .ACK_SLOT(ACK_SLOT));

/* ackctl_tb_top.sv */
// Self-checking bench for the acknowledge-bit control block
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; $display("BAD %0t mismatch", $time); end end
module ackctl_tb_top;
	// ========
	// Signals and model state
	logic clk = 1'b0, rst = 1'b1, tsel = 1'b0, got, flag_m = 1'b0, set_m = 1'b0, chk_m = 1'b0;
	logic oe_n, sout, avb, ace, afl, aslot, scl, psda, bst;
	logic [7:0] bsr;
	wire bus_sda = psda & (oe_n | sout);
	ackctl_pkg::ackctl_sw_s sw = '0;
	int failures = 0, check_count = 0, seed = 32'h18e7615a;
	// Clock
	initial forever #12.5 clk = ~clk;
	ackctl_peer peer (.clk(clk), .bus_sda(bus_sda), .scl(scl), .sda(psda), .bstart(bst));
	ackctl_top uut (.CORE_CLK(clk), .SYS_RST(rst), .SCL_IN(scl), .SDA_IN(bus_sda), .SDA_OUT(sout),
		.SDA_OE_N(oe_n), .TRANSMIT_SELECT(tsel), .BYTE_START(bst), .SW_CTRL(sw), .BUS_STATUS_REGISTER(bsr),
		.ACK_VALUE_BIT(avb), .ACK_CHECK_ENABLE(ace), .ACK_FLAG(afl), .ACK_SLOT(aslot));
	task results;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task cmp;
		#1;
		`CHK(afl, flag_m)
		`CHK(avb, tsel ? flag_m : set_m)
		`CHK(bsr, {7'h00, tsel ? flag_m : set_m})
		`CHK(ace, chk_m)
		`CHK(aslot, 1'b0)
		`CHK(sout, 1'b0)
	endtask
	// One software write strobe, then the model follows
	task sw_wr(input logic aw, input logic ad, input logic cw, input logic cdat);
		@(posedge clk);
		sw <= '{aw, ad, cw, cdat};
		@(posedge clk);
		sw <= '0;
		if (aw) set_m = ad;
		if (cw) chk_m = cdat;
		if (cw && !cdat) flag_m = 1'b0;
		cmp;
	endtask
	// One byte on the bus in the given direction
	task byte_run(input logic tx, input logic a);
		@(posedge clk);
		tsel <= tx;
		peer.xfer(8'($random(seed)), a, got);
		`CHK(got, tx ? a : set_m)
		if (tx && chk_m) flag_m = a;
		cmp;
	endtask
	// Main sequence
	initial
	begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		cmp;
		for (int k = 0; k < 6; k++)
		begin
			sw_wr(1'b0, 1'b0, 1'b1, k % 3 != 2);
			byte_run(1'b1, 1'($random(seed)));
			$display("tx byte %0d done", k);
		end
		sw_wr(1'b1, !flag_m, 1'b0, 1'b0);
		for (int k = 0; k < 4; k++)
		begin
			sw_wr(1'b1, 1'($random(seed)), 1'b0, 1'b0);
			byte_run(1'b0, 1'b1);
			$display("rx byte %0d done", k);
		end
		results;
	end
	// Watchdog
	initial
	begin
		repeat (20000) @(posedge clk);
		failures++;
		results;
	end
endmodule
